/* File: pkg/swc_pkg.sv */
// Constants and types shared by the sleep wake-up controller files.
package swc_pkg;

    // Special function register addresses on the core's register port.
    localparam logic [7:0] ADDR_TIMER_EXT_IRQ_CTRL = 8'h88;
    localparam logic [7:0] ADDR_RTC_CFG            = 8'hA1;
    localparam logic [7:0] ADDR_PORT0_PULLUP_EN    = 8'hB2;
    localparam logic [7:0] ADDR_PORT1_PULLUP_EN    = 8'hB3;
    localparam logic [7:0] ADDR_PORT2_PULLUP_EN    = 8'hB4;
    localparam logic [7:0] ADDR_POWER_CONTROL      = 8'hC5;
    localparam logic [7:0] ADDR_WAKE_CAUSE         = 8'hE8;
    localparam logic [7:0] ADDR_PM_IRQ_ENABLE      = 8'hEC;
    localparam logic [7:0] ADDR_TEMP_SUPPLY_DELTA  = 8'hF3;
    localparam logic [7:0] ADDR_MISC_POWER_CFG     = 8'hF4;
    localparam logic [7:0] ADDR_SCRATCH_FIRST      = 8'hFB;
    localparam logic [7:0] ADDR_SCRATCH_LAST       = 8'hFE;
    localparam logic [7:0] ADDR_EXT_PIN_WAKE_CFG   = 8'hFF;

    // Field positions.
    localparam int BIT_EXT_IRQ0_EDGE_SEL   = 0;
    localparam int BIT_EXT_IRQ0_FLAG       = 1;
    localparam int BIT_EXT_IRQ1_EDGE_SEL   = 2;
    localparam int BIT_EXT_IRQ1_FLAG       = 3;
    localparam int BIT_ALARM_WAKE_EN       = 1;
    localparam int BIT_SLEEP_CMD           = 4;
    localparam int BIT_EXT_VOLT_DELTA_EN   = 3;
    localparam int BIT_TEMP_MEAS_EN        = 3;
    localparam int BIT_RX_EDGE_FLAG        = 7;
    localparam int BIT_SWITCHED_SUPPLY_SRC = 6;
    localparam int BIT_LCD_SLEEP_EN        = 5;
    localparam int BIT_EXT_IRQ0_WAKE_CFG   = 0;
    localparam int MSB_EXT_IRQ1_WAKE_CFG   = 3;
    localparam int LSB_EXT_IRQ1_WAKE_CFG   = 1;
    localparam int MSB_RX_PIN_WAKE_CFG     = 1;

    // Wake cause bits, one per source but the receive pin.
    localparam int CAUSE_TEMP     = 0;
    localparam int CAUSE_VOLT     = 1;
    localparam int CAUSE_RESTORED = 2;
    localparam int CAUSE_MIDNIGHT = 3;
    localparam int CAUSE_ALARM    = 4;
    localparam int CAUSE_IRQ0     = 5;
    localparam int CAUSE_IRQ1     = 6;
    localparam int CAUSE_RESETPIN = 7;

    // Positions of the asynchronous inputs in the synchroniser vector.
    localparam int SYN_IRQ0     = 0;
    localparam int SYN_IRQ1     = 1;
    localparam int SYN_RX       = 2;
    localparam int SYN_RESET_N  = 3;
    localparam int SYN_MAIN     = 4;
    localparam int SYN_TEMP     = 5;
    localparam int SYN_VOLT     = 6;
    localparam int SYN_MIDNIGHT = 7;
    localparam int SYN_ALARM    = 8;
    localparam int SYN_COUNT    = 9;

    // Matching wake configuration codes.
    localparam logic [1:0] EXT_IRQ1_WAKE_CODE = 2'h3;
    localparam logic [1:0] RX_WAKE_CODE       = 2'h3;

    // Reset values of the registers.
    localparam logic [7:0] RST_REG8    = 8'h00;
    localparam logic [7:0] RST_PULLUP  = 8'hFF;

    // Core reset hold after a wake-up, as a time and in 100 MHz cycles.
    localparam int CLK_PERIOD_NS      = 10;
    localparam int WAKE_HOLD_NS       = 200;
    localparam int WAKE_HOLD_CYC      =
        (WAKE_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [7:0] WAKE_HOLD_CYC8 = 8'(WAKE_HOLD_CYC);

    // Operating modes, chosen by the supply feeding the switched output.
    typedef enum logic [1:0]
    {
        MODE_NORMAL  = 2'b00,
        MODE_BATTERY = 2'b01,
        MODE_SLEEP   = 2'b10
    } swc_mode_t;

    // Sequencer states.
    typedef enum logic [1:0]
    {
        ST_RUN   = 2'b00,
        ST_SLEEP = 2'b01,
        ST_WAKE  = 2'b10
    } swc_state_t;

endpackage : swc_pkg

/* File: pkg/swc_wake_if.sv */
// Interface carrying synchronised levels and edges between design modules.
interface swc_wake_if #(
    parameter int N = 9
);
    logic [N-1:0] level;  // Synchronised input levels.
    logic [N-1:0] rise;   // One-cycle pulse on a rising edge.
    logic [N-1:0] fall;   // One-cycle pulse on a falling edge.

    modport det (output level, output rise, output fall);
    modport ctl (input level, input rise, input fall);
endinterface : swc_wake_if

/* File: rtl/swc_wake_detect.sv */
// Two-stage synchronisers and edge detectors for the wake inputs.
module swc_wake_detect #(
    parameter int N = 9
)(
    input  wire logic clk,
    input  wire logic rst,
    input  wire logic [N-1:0] asyncIn,
    swc_wake_if.det   wk
);
    if (N < 1)
    begin : g_chk
        $error("swc_wake_detect needs at least one input");
    end

    logic [N-1:0] meta_r;  // First stage, read only by the second stage.
    logic [N-1:0] sync_r;  // Second stage, safe to use.
    logic [N-1:0] last_r;  // Previous synchronised value for edges.

    // Inputs are low after reset so a high pin gives one rising edge.
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            meta_r <= '0;
            sync_r <= '0;
            last_r <= '0;
        end
        else
        begin
            meta_r <= asyncIn;
            sync_r <= meta_r;
            last_r <= sync_r;
        end
    end

    // Edges are taken only from synchronised stages.
    assign wk.level = sync_r;
    assign wk.rise  = sync_r & ~last_r;
    assign wk.fall  = ~sync_r & last_r;
endmodule : swc_wake_detect

/* File: rtl/swc_sleep_wakeup_controller.sv */
// Sleep entry, wake-up sources and retained registers of the always-on side.
// What this block does
// RULE_01: Firmware clears wake flag before sleeping again.
// RULE_02: Temperature change wakes unless measurement disabled.
// RULE_03: Voltage delta sets flag, wakes when enabled.
// RULE_04: Supply restoration always wakes, flagged on vector.
// RULE_05: Bit 6 shows switched output on main.
// RULE_06: Midnight tick always wakes, raising clock flag.
// RULE_07: Alarm wakes only when enable bit set.
// RULE_08: Interrupt pin 0 wakes at config 1.
// RULE_09: Pin wake leaves edge flags untouched.
// RULE_10: Interrupt pin 1 wakes at config 11x.
// RULE_11: Receive edges wake at config 11, flag.
// RULE_12: Reset pin low always wakes to battery.
// RULE_13: LCD optional in sleep, segment memory kept.
// RULE_14: Four scratch registers keep contents through sleep.
// RULE_15: Pins are inputs in sleep, wakes maskable.
// RULE_16: Pull-ups disableable per pin, one register/port.
// RULE_17: Operating mode follows switched supply source.
// RULE_18: Sleep removes core supply, core state lost.
// RULE_19: Writing bit 4 of power control sleeps.
// RULE_20: Wake restarts core from reset vector, battery.
// RULE_21: Wake request ORs enabled and nonmaskable sources.
// RULE_22: Wake inputs synchronised on always-on clock first.
module swc_sleep_wakeup_controller
    import swc_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic [7:0]  sfrAddr,
    input  wire logic [7:0]  sfrWrData,
    input  wire logic        sfrWr,
    input  wire logic        sfrRd,
    output logic      [7:0]  sfrRdData,
    input  wire logic        extIrq0PinN,
    input  wire logic        extIrq1PinN,
    input  wire logic        rxPin,
    input  wire logic        resetPinN,
    input  wire logic        switchedSupplyOnMain,
    input  wire logic        tempDelta,
    input  wire logic        extVoltageDelta,
    input  wire logic        midnightTick,
    input  wire logic        alarmTick,
    output swc_mode_t        opMode,
    output logic             coreSupplyEn,
    output logic             coreResetReq,
    output logic             ioForceInput,
    output logic             lcdDriverOn,
    output logic      [7:0]  port0PullupEn,
    output logic      [7:0]  port1PullupEn,
    output logic      [7:0]  port2PullupEn
);
    if (WAKE_HOLD_CYC < 1 || WAKE_HOLD_CYC > 255)
    begin : g_chk
        $error("wake hold count must fit 1 to 255 cycles");
    end

    // Synchronised inputs and their edges.
    swc_wake_if #(.N(SYN_COUNT)) wk ();
    logic [SYN_COUNT-1:0] asyncVec;  // All asynchronous wake inputs.

    assign asyncVec = {alarmTick, midnightTick, extVoltageDelta, tempDelta,
                       switchedSupplyOnMain, resetPinN, rxPin,
                       extIrq1PinN, extIrq0PinN};

    // Every wake input crosses two flops before any logic sees it.
    swc_wake_detect #(.N(SYN_COUNT)) u_detect (  // RULE_22
        .clk     (clk),
        .rst     (rst),
        .asyncIn (asyncVec),
        .wk      (wk)
    );

    // Software-visible registers; each _nxt is the value for the next edge.
    logic [7:0] timerCtrl_r;   // Timer and external interrupt control.
    logic [7:0] rtcCfg_r;      // Clock configuration.
    logic [7:0] pullup_r [3];  // One pull-up enable register per port.
    logic [7:0] pmIrqEn_r;     // Power management interrupt enables.
    logic [7:0] tempCfg_r;     // Temperature and supply delta setup.
    logic [7:0] miscCfg_r;     // Writable part of misc power config.
    logic [7:0] pinWakeCfg_r;  // Interrupt pin wake configuration.
    logic [7:0] scratch_r [4]; // Scratch pad kept through sleep.
    logic [7:0] cause_r;       // Sticky wake causes.
    logic [7:0] cause_nxt;
    logic       rxFlag_r;      // Receive edge flag.
    logic       rxFlag_nxt;
    logic [7:0] rdData_r;      // Registered read data.
    swc_state_t state_r;       // Sequencer state.
    swc_state_t state_nxt;
    logic [7:0] holdCnt_r;     // Core reset hold counter.
    logic [7:0] holdCnt_nxt;
    swc_mode_t  mode_r;        // Operating mode.
    swc_mode_t  mode_nxt;
    logic       supplyOn_r;    // Core supply enable.
    logic       coreRst_r;     // Core held in reset.
    logic       ioIn_r;        // I/O forced to inputs.
    logic       lcdOn_r;       // LCD driver running.

    // Register decode: one write strobe per register but the pull-ups, then the scratch pad.
    wire logic       wrTimer  = sfrWr && sfrAddr == ADDR_TIMER_EXT_IRQ_CTRL;
    wire logic       wrRtc    = sfrWr && sfrAddr == ADDR_RTC_CFG;
    wire logic       wrPmEn   = sfrWr && sfrAddr == ADDR_PM_IRQ_ENABLE;
    wire logic       wrTemp   = sfrWr && sfrAddr == ADDR_TEMP_SUPPLY_DELTA;
    wire logic       wrMisc   = sfrWr && sfrAddr == ADDR_MISC_POWER_CFG;
    wire logic       wrPinCfg = sfrWr && sfrAddr == ADDR_EXT_PIN_WAKE_CFG;
    wire logic       wrPower  = sfrWr && sfrAddr == ADDR_POWER_CONTROL;
    wire logic       wrCause  = sfrWr && sfrAddr == ADDR_WAKE_CAUSE;
    wire logic       isScratch = sfrAddr >= ADDR_SCRATCH_FIRST &&
                                 sfrAddr <= ADDR_SCRATCH_LAST;
    // Only the low two offset bits pick one of the four entries.
    wire logic [7:0] scratchOfs = sfrAddr - ADDR_SCRATCH_FIRST;
    wire logic [1:0] scratchIdx = scratchOfs[1:0];
    logic      [7:0] miscRead;  // Misc register as read.
    logic      [7:0] rdMux;     // Selected read value.

    // Source conditions; input terms come from synchronised levels and edges, the rest from state and config.
    wire logic       sleeping   = state_r == ST_SLEEP;
    wire logic       onMain     = wk.level[SYN_MAIN];
    wire logic       restored   = wk.rise[SYN_MAIN];
    wire logic       resetLow   = ~wk.level[SYN_RESET_N];
    // Edge select set takes the falling edge, clear takes the rising one.
    wire logic       irq0Edge   = timerCtrl_r[BIT_EXT_IRQ0_EDGE_SEL] ?
        wk.fall[SYN_IRQ0] : wk.rise[SYN_IRQ0];  // RULE_08
    wire logic       irq1Edge   = timerCtrl_r[BIT_EXT_IRQ1_EDGE_SEL] ?
        wk.fall[SYN_IRQ1] : wk.rise[SYN_IRQ1];  // RULE_10
    wire logic       irq0WakeOn =
        pinWakeCfg_r[BIT_EXT_IRQ0_WAKE_CFG];  // RULE_08
    wire logic       irq1WakeOn = pinWakeCfg_r[MSB_EXT_IRQ1_WAKE_CFG:
        LSB_EXT_IRQ1_WAKE_CFG + 1] == EXT_IRQ1_WAKE_CODE;  // RULE_10
    wire logic       rxWakeOn   =
        miscCfg_r[MSB_RX_PIN_WAKE_CFG:0] == RX_WAKE_CODE;
    wire logic       rxEdge     = wk.rise[SYN_RX] | wk.fall[SYN_RX]; // RULE_11
    logic      [7:0] causeSet;  // Causes seen this cycle.

    // Pin wake events count only while the pins are wake inputs.
    assign causeSet[CAUSE_TEMP]     = wk.rise[SYN_TEMP];
    assign causeSet[CAUSE_VOLT]     = wk.rise[SYN_VOLT];      // RULE_03
    assign causeSet[CAUSE_RESTORED] = restored;               // RULE_04
    assign causeSet[CAUSE_MIDNIGHT] = wk.rise[SYN_MIDNIGHT];  // RULE_06
    assign causeSet[CAUSE_ALARM]    = wk.rise[SYN_ALARM];
    assign causeSet[CAUSE_IRQ0]     = irq0Edge & irq0WakeOn & sleeping;
    assign causeSet[CAUSE_IRQ1]     = irq1Edge & irq1WakeOn & sleeping;
    assign causeSet[CAUSE_RESETPIN] = resetLow & sleeping;    // RULE_12

    // A write of one clears a cause, but a new event in that cycle wins.
    assign cause_nxt  = (cause_r & ~(wrCause ? sfrWrData : 8'h00))
                        | causeSet;
    // Writing zero clears the receive flag; a fresh edge still sets it.
    assign rxFlag_nxt = (rxFlag_r & ~(wrMisc &
                        ~sfrWrData[BIT_RX_EDGE_FLAG])) |
                        (rxEdge & rxWakeOn);                  // RULE_11

    // Pending flags keep requesting, so an uncleared cause wakes again.
    wire logic       wakeMaskable =
        (cause_r[CAUSE_TEMP] & tempCfg_r[BIT_TEMP_MEAS_EN]) |    // RULE_02
        (cause_r[CAUSE_VOLT] & pmIrqEn_r[BIT_EXT_VOLT_DELTA_EN]) | // RULE_03
        (cause_r[CAUSE_ALARM] & rtcCfg_r[BIT_ALARM_WAKE_EN]) |   // RULE_07
        (cause_r[CAUSE_IRQ0] & irq0WakeOn) |                     // RULE_15
        (cause_r[CAUSE_IRQ1] & irq1WakeOn) |
        (rxFlag_r & rxWakeOn);
    wire logic       wakeFixed =
        cause_r[CAUSE_RESTORED] | cause_r[CAUSE_MIDNIGHT] |
        cause_r[CAUSE_RESETPIN] | onMain;
    wire logic       wakeReq   = wakeMaskable | wakeFixed;  // RULE_21

    // Sequencer: run, sleep with the core unpowered, then a reset hold.
    always_comb
    begin
        state_nxt   = state_r;
        holdCnt_nxt = holdCnt_r;
        case (state_r)
            ST_RUN:
            begin
                // The command is ignored while on main supply.
                if (wrPower && sfrWrData[BIT_SLEEP_CMD] && !onMain)
                begin
                    state_nxt = ST_SLEEP;  // RULE_19
                end
            end
            ST_SLEEP:
            begin
                if (wakeReq)
                begin
                    state_nxt   = ST_WAKE;
                    holdCnt_nxt = WAKE_HOLD_CYC8;
                end
            end
            ST_WAKE:
            begin
                // Hold the core in reset so it starts at the reset vector.
                if (holdCnt_r == 8'h01)
                begin
                    state_nxt = ST_RUN;  // RULE_20
                end
                holdCnt_nxt = holdCnt_r - 8'h01;
            end
            default:
            begin
                state_nxt = ST_RUN;
            end
        endcase
    end

    // Mode follows the supply, and sleep only exists on battery.
    assign mode_nxt = onMain ? MODE_NORMAL :                  // RULE_17
                      (state_nxt == ST_SLEEP ? MODE_SLEEP : MODE_BATTERY);

    // Misc register: flag, supply source bit and the writable fields.
    assign miscRead = {rxFlag_r, onMain, miscCfg_r[5:0]};     // RULE_05

    // Read mux; unmapped addresses and the sleep command read as zero.
    assign rdMux =
        sfrAddr == ADDR_TIMER_EXT_IRQ_CTRL ? timerCtrl_r :
        sfrAddr == ADDR_RTC_CFG            ? rtcCfg_r    :
        sfrAddr == ADDR_PORT0_PULLUP_EN    ? pullup_r[0] :
        sfrAddr == ADDR_PORT1_PULLUP_EN    ? pullup_r[1] :
        sfrAddr == ADDR_PORT2_PULLUP_EN    ? pullup_r[2] :
        sfrAddr == ADDR_WAKE_CAUSE         ? cause_r     :
        sfrAddr == ADDR_PM_IRQ_ENABLE      ? pmIrqEn_r   :
        sfrAddr == ADDR_TEMP_SUPPLY_DELTA  ? tempCfg_r   :
        sfrAddr == ADDR_MISC_POWER_CFG     ? miscRead    :
        sfrAddr == ADDR_EXT_PIN_WAKE_CFG   ? pinWakeCfg_r :
        isScratch ? scratch_r[scratchIdx] : 8'h00;

    // Configuration registers; wake never touches the edge flags.
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            timerCtrl_r  <= RST_REG8;
            rtcCfg_r     <= RST_REG8;
            pmIrqEn_r    <= RST_REG8;
            tempCfg_r    <= RST_REG8;
            miscCfg_r    <= RST_REG8;
            pinWakeCfg_r <= RST_REG8;
        end
        else
        begin
            if (wrTimer)
                timerCtrl_r <= sfrWrData;  // RULE_09
            if (wrRtc)
                rtcCfg_r <= sfrWrData;
            if (wrPmEn)
                pmIrqEn_r <= sfrWrData;
            if (wrTemp)
                tempCfg_r <= sfrWrData;
            if (wrMisc)
                miscCfg_r <= sfrWrData;
            if (wrPinCfg)
                pinWakeCfg_r <= sfrWrData;
        end
    end

    // Pull-ups and scratch pad take their reset values only at power-on, never on wake.
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            pullup_r  <= '{default: RST_PULLUP};
            scratch_r <= '{default: RST_REG8};
        end
        else
        begin
            if (sfrWr && sfrAddr >= ADDR_PORT0_PULLUP_EN &&
                sfrAddr <= ADDR_PORT2_PULLUP_EN)
            begin
                pullup_r[2'(sfrAddr - ADDR_PORT0_PULLUP_EN)] <=
                    sfrWrData;  // RULE_16
            end
            if (sfrWr && isScratch)
            begin
                scratch_r[scratchIdx] <= sfrWrData;  // RULE_14
            end
        end
    end

    // Flags, sequencer and power outputs.
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            cause_r    <= RST_REG8;
            rxFlag_r   <= 1'b0;
            state_r    <= ST_RUN;
            holdCnt_r  <= 8'h00;
            mode_r     <= MODE_BATTERY;
            supplyOn_r <= 1'b1;
            coreRst_r  <= 1'b0;
            ioIn_r     <= 1'b0;
            lcdOn_r    <= 1'b1;
            rdData_r   <= 8'h00;
        end
        else
        begin
            cause_r    <= cause_nxt;
            rxFlag_r   <= rxFlag_nxt;
            state_r    <= state_nxt;
            holdCnt_r  <= holdCnt_nxt;
            mode_r     <= mode_nxt;
            supplyOn_r <= state_nxt != ST_SLEEP;  // RULE_18
            coreRst_r  <= state_nxt != ST_RUN;    // RULE_20
            ioIn_r     <= state_nxt == ST_SLEEP;  // RULE_15
            // The segment memory is not cleared here in any state.
            lcdOn_r    <= state_nxt != ST_SLEEP ||
                          miscCfg_r[BIT_LCD_SLEEP_EN];  // RULE_13
            if (sfrRd)
            begin
                rdData_r <= rdMux;
            end
        end
    end

    // Every output comes straight from a flop.
    assign sfrRdData     = rdData_r;
    assign opMode        = mode_r;
    assign coreSupplyEn  = supplyOn_r;
    assign coreResetReq  = coreRst_r;
    assign ioForceInput  = ioIn_r;
    assign lcdDriverOn   = lcdOn_r;
    assign port0PullupEn = pullup_r[0];
    assign port1PullupEn = pullup_r[1];
    assign port2PullupEn = pullup_r[2];
endmodule : swc_sleep_wakeup_controller

/* File: dv/swc_chk.sv */
// Port-level assertions for the sleep wake-up controller.
module swc_chk
    import swc_pkg::*;
(
    input wire logic       clk,
    input wire logic       rst,
    input wire logic [7:0] sfrAddr,
    input wire logic [7:0] sfrWrData,
    input wire logic       sfrWr,
    input wire logic       sfrRd,
    input wire logic [7:0] sfrRdData,
    input wire logic       resetPinN,
    input wire logic       switchedSupplyOnMain,
    input swc_mode_t       opMode,
    input wire logic       coreSupplyEn,
    input wire logic       coreResetReq,
    input wire logic       ioForceInput,
    input wire logic [7:0] port0PullupEn
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    // A wake-up is the core supply coming back on.
    sequence wake_s;
        $rose(coreSupplyEn);
    endsequence
    // The core is held in reset for the hold time, then released.
    sequence hold_s;
        coreResetReq [*8] ##[10:14] !coreResetReq;
    endsequence
    a_wake_hold: assert property (wake_s |-> hold_s)
        else $error("core reset hold wrong after wake");
    a_wake_mode: assert property (wake_s and !switchedSupplyOnMain
        |-> opMode == MODE_BATTERY) else $error("wake not to battery");
    a_sleep_state: assert property (opMode == MODE_SLEEP
        |-> !coreSupplyEn && ioForceInput && coreResetReq)
        else $error("core not off in sleep");
    a_sleep_cmd: assert property ((!switchedSupplyOnMain) [*4] ##0
        (sfrWr && sfrAddr == ADDR_POWER_CONTROL && sfrWrData[BIT_SLEEP_CMD]
        && coreSupplyEn && !coreResetReq) |=> coreResetReq)
        else $error("sleep command not taken");
    a_pullup_wr: assert property (sfrWr && sfrAddr == ADDR_PORT0_PULLUP_EN
        |-> ##2 port0PullupEn == $past(sfrWrData, 2))
        else $error("pull-up write lost");
    a_reset_wake: assert property (opMode == MODE_SLEEP ##0
        (!resetPinN) [*4] |-> ##[0:4] coreSupplyEn)
        else $error("reset pin did not wake");
    a_main_mode: assert property (switchedSupplyOnMain [*8]
        |-> opMode == MODE_NORMAL) else $error("mode not normal on main");
    a_main_flag: assert property (switchedSupplyOnMain [*6] ##0
        (sfrRd && sfrAddr == ADDR_MISC_POWER_CFG)
        |-> ##2 sfrRdData[BIT_SWITCHED_SUPPLY_SRC])
        else $error("supply source bit clear on main");
endmodule : swc_chk

bind swc_sleep_wakeup_controller swc_chk swc_chk_inst (
    .clk, .rst, .sfrAddr, .sfrWrData, .sfrWr, .sfrRd, .sfrRdData,
    .resetPinN, .switchedSupplyOnMain, .opMode, .coreSupplyEn,
    .coreResetReq, .ioForceInput, .port0PullupEn
);

/* File: dv/swc_core_model.sv */
// Behavioural core that drives the register port as firmware would.
module swc_core_model
    import swc_pkg::*;
(
    input  wire logic       clk,
    output logic      [7:0] sfrAddr,
    output logic      [7:0] sfrWrData,
    output logic            sfrWr,
    output logic            sfrRd,
    input  wire logic [7:0] sfrRdData
);
    timeunit 1ns;
    timeprecision 1ps;
    // The bus idles from time zero so nothing is taken by accident.
    initial
    begin
        {sfrAddr, sfrWrData, sfrWr, sfrRd} = 18'h00000;
    end
    // One write; the strobe is a one-cycle pulse.
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        sfrAddr <= a;
        sfrWrData <= d;
        sfrWr <= 1'b1;
        @(posedge clk);
        sfrWr <= 1'b0;
    endtask : wr
    // Read data is registered and holds, so it is taken a cycle late.
    task automatic rd(input logic [7:0] a, output logic [7:0] q);
        @(posedge clk);
        sfrAddr <= a;
        sfrRd <= 1'b1;
        @(posedge clk);
        sfrRd <= 1'b0;
        @(posedge clk);
        @(negedge clk);
        q = sfrRdData;
    endtask : rd
    // Serviced causes are cleared first, or the part would wake at once.
    task automatic nap();
        wr(ADDR_WAKE_CAUSE, 8'hFF);
        wr(ADDR_POWER_CONTROL, 8'h10);
    endtask : nap
endmodule : swc_core_model

/* File: dv/tb.sv */
// Self-checking bench for the sleep wake-up controller.
module tb
    import swc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct {logic [7:0] a; logic [7:0] d; int s; logic w;} swc_row_t;
    logic clk, rst, sfrWr, sfrRd, resetPinN, switchedSupplyOnMain;
    logic [7:0] sfrAddr, sfrWrData, sfrRdData, q;
    logic [6:0] ev;  // Event lines, one bit per wake source but the supply and the reset pin.
    logic extIrq0PinN, extIrq1PinN, rxPin;
    logic tempDelta, extVoltageDelta, midnightTick, alarmTick;
    swc_mode_t opMode;
    logic coreSupplyEn, coreResetReq, ioForceInput, lcdDriverOn;
    logic [7:0] port0PullupEn, port1PullupEn, port2PullupEn;
    int n_fail = 0;
    int n_compared = 0;
    // Config write, source to fire, and whether a wake must follow.
    swc_row_t rows [11] = '{'{8'hF3, 8'h00, 0, 1'b0},
        '{8'hF3, 8'h08, 0, 1'b1}, '{8'hEC, 8'h00, 1, 1'b0},
        '{8'hEC, 8'h08, 1, 1'b1}, '{8'h88, 8'h0A, 2, 1'b1},
        '{8'hA1, 8'h00, 3, 1'b0}, '{8'hA1, 8'h02, 3, 1'b1},
        '{8'hFF, 8'h00, 4, 1'b0}, '{8'hFF, 8'h01, 4, 1'b1},
        '{8'hFF, 8'h0C, 5, 1'b1}, '{8'hFF, 8'h08, 5, 1'b0}};
    // Pins are active low and idle high; the event bits idle low.
    assign {alarmTick, midnightTick, extVoltageDelta, tempDelta} = ev[3:0];
    assign {rxPin, extIrq1PinN, extIrq0PinN} = ~ev[6:4];
    swc_sleep_wakeup_controller swc_sleep_wakeup_controller_inst (
        .clk, .rst, .sfrAddr, .sfrWrData, .sfrWr, .sfrRd, .sfrRdData,
        .extIrq0PinN, .extIrq1PinN, .rxPin, .resetPinN,
        .switchedSupplyOnMain, .tempDelta, .extVoltageDelta,
        .midnightTick, .alarmTick, .opMode, .coreSupplyEn, .coreResetReq,
        .ioForceInput, .lcdDriverOn, .port0PullupEn, .port1PullupEn,
        .port2PullupEn);
    swc_core_model swc_core_model_inst (
        .clk, .sfrAddr, .sfrWrData, .sfrWr, .sfrRd, .sfrRdData);
    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            n_fail++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : cmp
    task automatic summarize();
        $display("compared %0d mismatched %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : summarize
    // Each source event is held three cycles, past the synchroniser.
    task automatic kick(input int s);
        @(posedge clk);
        ev[s] <= 1'b1;
        repeat (3) @(posedge clk);
        ev[s] <= 1'b0;
    endtask : kick
    task automatic nap_chk();
        swc_core_model_inst.nap();
        repeat (2) @(posedge clk);
        cmp(8'(opMode), 8'(MODE_SLEEP));
    endtask : nap_chk
    // A missing wake is recovered with the reset pin, which always wakes.
    task automatic await_wake(input logic exp);
        int i;
        for (i = 0; i < 30 && coreSupplyEn !== 1'b1; i++) @(posedge clk);
        cmp(8'(coreSupplyEn), 8'(exp));
        if (coreSupplyEn !== 1'b1)
        begin
            resetPinN <= 1'b0;
            repeat (4) @(posedge clk);
            resetPinN <= 1'b1;
        end
        for (i = 0; i < 40 && coreResetReq !== 1'b0; i++) @(posedge clk);
        if (i == 40)
        begin
            n_fail++;
            summarize();
        end
    endtask : await_wake
    initial
    begin
        {rst, ev, resetPinN, switchedSupplyOnMain} = {1'b1, 7'h00, 2'b10};
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        repeat (8) @(posedge clk);
        for (int k = 0; k < 7; k++)
            swc_core_model_inst.wr(k < 3 ? 8'hB2 + k : 8'hF8 + k, 8'hA0 + k);
        foreach (rows[k])
        begin
            swc_core_model_inst.wr(rows[k].a, rows[k].d);
            nap_chk();
            kick(rows[k].s);
            await_wake(rows[k].w);
            cmp(8'(opMode), 8'(MODE_BATTERY));
        end
        $display("test wake table done");
        for (int k = 0; k < 4; k++)
        begin
            swc_core_model_inst.rd(8'hFB + k, q);
            cmp(q, 8'hA3 + k);
        end
        cmp(port2PullupEn, 8'hA2);
        swc_core_model_inst.rd(8'h88, q);
        cmp(q, 8'h0A);
        swc_core_model_inst.wr(8'hF4, 8'h03);
        nap_chk();
        cmp(8'(lcdDriverOn), 8'h00);
        kick(6);
        await_wake(1'b1);
        swc_core_model_inst.rd(8'hF4, q);
        cmp(q, 8'h83);
        swc_core_model_inst.wr(8'hF4, 8'h00);
        $display("test retention and receive edge done");
        nap_chk();
        switchedSupplyOnMain <= 1'b1;
        await_wake(1'b1);
        swc_core_model_inst.rd(8'hF4, q);
        cmp(q, 8'h40);
        swc_core_model_inst.nap();
        repeat (4) @(posedge clk);
        cmp(8'(opMode), 8'(MODE_NORMAL));
        switchedSupplyOnMain <= 1'b0;
        repeat (8) @(posedge clk);
        cmp(8'(opMode), 8'(MODE_BATTERY));
        $display("test supply restore done");
        rst <= 1'b1;
        repeat (3) @(posedge clk);
        cmp(port0PullupEn, RST_PULLUP);
        rst <= 1'b0;
        swc_core_model_inst.rd(8'hFB, q);
        cmp(q, RST_REG8);
        swc_core_model_inst.rd(8'h90, q);
        cmp(q, 8'h00);
        $display("test mid-run reset done");
        summarize();
    end
endmodule : tb
